// ---- scm_cfg.svh ----
/*
  Constants of the serial console monitor: character codes, selectors, widths.
  Assumes inclusion by bare name from the monitor design file only.
*/
// Functional notes
// (RULE1) Slash after specifier opens location, prints six digits and a space.
// (RULE2) Bare slash reopens previous location, only as first character after prompt.
// (RULE3) Bare slash before any open location answers question mark, CR, LF.
// (RULE4) Octal specifiers need no leading zeros.
// (RULE5) CR closes location, deposits typed data, else leaves it unchanged.
// (RULE6) CR is echoed, then CR, LF and prompt follow.
// (RULE7) LF closes, stores data, opens next: address plus two, register plus one.
// (RULE8) LF on open status word closes it, prints CR LF prompt, opens nothing.
// (RULE9) LF from program counter wraps to register zero.
// (RULE10) LF from last address of 32-Kword segment wraps to segment start.
// (RULE11) LF is not echoed; CR then LF are printed instead.
// (RULE12) Codes 0, 2, 10 not echoed; answered with ?, CR, LF, prompt.
// (RULE13) Dollar or R then digit or S opens that register or status word.
// (RULE14) Last designator character selects; trailing 077 or 477 means status word.
// (RULE15) Operator types S only after a register designator.
// (RULE16) Status word deposits leave the trace bit unchanged.
// (RULE17) Go: echo, two nulls, load counter, clear status words, initialise bus.
// (RULE18) After go, service state; halt asserted returns to monitor without running.
// (RULE19) Proceed resumes at counter, unchanged state, start as echo begins.
// (RULE20) Halt recognised at instruction end; monitor re-entered, prints counter.
// (RULE21) Physical address is 18 bits in one variant and 22 in the other.
// (RULE22) Halt-toggle command flips internal halt flip-flop where supported.
// (RULE23) Typed octal digits accumulate into one specifier or data value.
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH
`define SCM_CH_NUL 8'h00
`define SCM_CH_STX 8'h02
`define SCM_CH_BS 8'h08
`define SCM_CH_LF 8'h0A
`define SCM_CH_CR 8'h0D
`define SCM_CH_SP 8'h20
`define SCM_CH_DOL 8'h24
`define SCM_CH_SLASH 8'h2F
`define SCM_CH_ZERO 8'h30
`define SCM_CH_SEVEN 8'h37
`define SCM_CH_QM 8'h3F
`define SCM_CH_AT 8'h40
`define SCM_CH_G 8'h47
`define SCM_CH_H 8'h48
`define SCM_CH_P 8'h50
`define SCM_CH_R 8'h52
`define SCM_CH_S 8'h53
`define SCM_PSW_SEL 9'h03F
`define SCM_PSW_SEL_ALT 9'h13F
`define SCM_TRACE_BIT 4
`define SCM_SEG_BITS 16
`define SCM_PC_REG 3'h7
`define SCM_PRINT_DIGITS 6
`endif

// ---- scm_monitor.sv ----
/*
  Console monitor: interprets received characters, examines and deposits
  bus words, general registers and the status word, starts and resumes the
  processor. Assumes a receiver giving one-cycle character strobes, a bus
  port with request/done handshake, and a processor core with run/halt.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scm_cfg.svh"
module scm_monitor #(
  // (RULE21) Address width per variant
  parameter int ADDR_W = 22,
  parameter bit HALT_TOGGLE_EN = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  input wire logic [15:0] i_mem_rdata,
  input wire logic i_mem_done,
  output logic o_reg_we,
  output logic [2:0] o_reg_sel,
  output logic [15:0] o_reg_wdata,
  input wire logic [15:0] i_reg_rdata,
  output logic o_psw_we,
  output logic [15:0] o_psw_wdata,
  input wire logic [15:0] i_psw_rdata,
  output logic o_fps_clear,
  output logic o_bus_init,
  output logic o_run,
  input wire logic i_halt_sw,
  input wire logic i_core_halted,
  input wire logic [15:0] i_pc,
  output logic o_halt_ff
);
  if (ADDR_W != 18 && ADDR_W != 22) begin : g_bad_addr_w
    $error("ADDR_W must be 18 or 22");
  end

  typedef enum logic [3:0] {
    SCM_ST_PROMPT, SCM_ST_IDLE, SCM_ST_FETCH, SCM_ST_PRINT, SCM_ST_STORE,
    SCM_ST_MSG, SCM_ST_START, SCM_ST_RUN, SCM_ST_REENTRY
  } scm_state_t;

  scm_tx_if txc ();
  scm_tx_stage u_tx (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .tx(txc),
    .i_tx_ready(i_tx_ready),
    .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data)
  );

  scm_state_t st_r;
  scm_pkg::scm_loc_t loc_r;
  logic [ADDR_W-1:0] addr_r;
  logic [2:0] reg_r;
  // Accumulator as wide as an address, so upper address digits survive
  logic [ADDR_W-1:0] acc_r;
  logic [15:0] word_r, pc_show_r;
  logic [8:0] desig_r;
  logic have_r, first_r, opened_r, in_reg_r, desig_s_r, closed_r;
  logic [1:0] after_r;
  logic [7:0] msg_r [0:7];
  logic [2:0] msg_len_r, msg_idx_r;
  logic [1:0] go_step_r;
  logic halt_q1_r, halt_q2_r;

  // Forms the character of an octal digit given as three bits
  function automatic logic [7:0] scm_oct_char(input logic [2:0] d);
    return {5'b00110, d};
  endfunction : scm_oct_char

  function automatic logic scm_is_oct(input logic [7:0] c);
    return c >= `SCM_CH_ZERO && c <= `SCM_CH_SEVEN;
  endfunction : scm_is_oct

  wire take = i_rx_valid && st_r == SCM_ST_IDLE;
  wire halt_req = halt_q2_r || o_halt_ff;
  wire [15:0] dep_word = (loc_r == scm_pkg::SCM_LOC_PSW) ?
    // (RULE16) Trace bit kept
    {acc_r[15:`SCM_TRACE_BIT+1], i_psw_rdata[`SCM_TRACE_BIT], acc_r[`SCM_TRACE_BIT-1:0]} :
    acc_r[15:0];

  // Halt switch is an off-chip level
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      halt_q1_r <= 1'b0;
      halt_q2_r <= 1'b0;
    end else begin
      halt_q1_r <= i_halt_sw;
      halt_q2_r <= halt_q1_r;
    end
  end

  // Message sender: one character per accepted hand-off
  assign txc.valid = st_r == SCM_ST_MSG;
  assign txc.data = msg_r[msg_idx_r];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r <= SCM_ST_PROMPT;
      loc_r <= scm_pkg::SCM_LOC_NONE;
      addr_r <= '0;
      reg_r <= 3'h0;
      acc_r <= '0;
      word_r <= 16'h0000;
      pc_show_r <= 16'h0000;
      desig_r <= 9'h000;
      have_r <= 1'b0;
      first_r <= 1'b1;
      opened_r <= 1'b0;
      in_reg_r <= 1'b0;
      desig_s_r <= 1'b0;
      closed_r <= 1'b1;
      after_r <= 2'h0;
      msg_len_r <= 3'h0;
      msg_idx_r <= 3'h0;
      go_step_r <= 2'h0;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= '0;
      o_mem_wdata <= 16'h0000;
      o_reg_we <= 1'b0;
      o_reg_sel <= 3'h0;
      o_reg_wdata <= 16'h0000;
      o_psw_we <= 1'b0;
      o_psw_wdata <= 16'h0000;
      o_fps_clear <= 1'b0;
      o_bus_init <= 1'b0;
      o_run <= 1'b0;
      o_halt_ff <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        msg_r[i] <= 8'h00;
      end
    end else begin
      o_reg_we <= 1'b0;
      o_psw_we <= 1'b0;
      o_fps_clear <= 1'b0;
      o_bus_init <= 1'b0;
      unique case (st_r)
        SCM_ST_PROMPT: begin
          msg_r[0] <= `SCM_CH_AT;
          msg_len_r <= 3'h0;
          msg_idx_r <= 3'h0;
          after_r <= 2'h2;
          first_r <= 1'b1;
          have_r <= 1'b0;
          acc_r <= '0;
          in_reg_r <= 1'b0;
          desig_s_r <= 1'b0;
          st_r <= SCM_ST_MSG;
        end
        SCM_ST_IDLE: begin
          if (take) begin
            first_r <= 1'b0;
            if (i_rx_data == `SCM_CH_NUL || i_rx_data == `SCM_CH_STX ||
                i_rx_data == `SCM_CH_BS) begin
              // (RULE12) Reject unechoed codes
              msg_r[0] <= `SCM_CH_QM;
              msg_r[1] <= `SCM_CH_CR;
              msg_r[2] <= `SCM_CH_LF;
              msg_len_r <= 3'h2;
              msg_idx_r <= 3'h0;
              after_r <= 2'h1;
              st_r <= SCM_ST_MSG;
            end else if (scm_is_oct(i_rx_data)) begin
              if (in_reg_r) begin
                desig_r <= {desig_r[5:0], i_rx_data[2:0]};
                desig_s_r <= 1'b0;
              end else begin
                // (RULE4) (RULE23) Accumulate octal
                acc_r <= {acc_r[ADDR_W-4:0], i_rx_data[2:0]};
              end
              have_r <= 1'b1;
              msg_r[0] <= i_rx_data;
              msg_len_r <= 3'h0;
              msg_idx_r <= 3'h0;
              after_r <= 2'h2;
              st_r <= SCM_ST_MSG;
            end else if (i_rx_data == `SCM_CH_DOL || i_rx_data == `SCM_CH_R) begin
              in_reg_r <= 1'b1;
              desig_r <= 9'h000;
              msg_r[0] <= i_rx_data;
              msg_len_r <= 3'h0;
              msg_idx_r <= 3'h0;
              after_r <= 2'h2;
              st_r <= SCM_ST_MSG;
            end else if (i_rx_data == `SCM_CH_S && in_reg_r) begin
              // (RULE15) S only after designator
              desig_s_r <= 1'b1;
              have_r <= 1'b1;
              msg_r[0] <= i_rx_data;
              msg_len_r <= 3'h0;
              msg_idx_r <= 3'h0;
              after_r <= 2'h2;
              st_r <= SCM_ST_MSG;
            end else if (i_rx_data == `SCM_CH_SLASH) begin
              msg_r[0] <= i_rx_data;
              msg_len_r <= 3'h0;
              msg_idx_r <= 3'h0;
              if (in_reg_r) begin
                // (RULE13) (RULE14) Register select
                if (desig_s_r || desig_r == `SCM_PSW_SEL || desig_r == `SCM_PSW_SEL_ALT) begin
                  loc_r <= scm_pkg::SCM_LOC_PSW;
                end else begin
                  loc_r <= scm_pkg::SCM_LOC_REG;
                  reg_r <= desig_r[2:0];
                end
                after_r <= 2'h3;
              end else if (have_r) begin
                // (RULE1) Open bus location
                loc_r <= scm_pkg::SCM_LOC_BUS;
                addr_r <= acc_r;
                after_r <= 2'h3;
              end else if (first_r && opened_r) begin
                // (RULE2) Reopen previous
                after_r <= 2'h3;
              end else begin
                // (RULE3) Nothing opened yet, or bare slash not first after prompt
                msg_r[1] <= `SCM_CH_QM;
                msg_r[2] <= `SCM_CH_CR;
                msg_r[3] <= `SCM_CH_LF;
                msg_len_r <= 3'h3;
                after_r <= 2'h1;
              end
              acc_r <= '0;
              have_r <= 1'b0;
              in_reg_r <= 1'b0;
              st_r <= SCM_ST_MSG;
            end else if (i_rx_data == `SCM_CH_CR || i_rx_data == `SCM_CH_LF) begin
              if (!closed_r && have_r) begin
                // (RULE5) Deposit before close
                st_r <= SCM_ST_STORE;
                o_mem_we <= loc_r == scm_pkg::SCM_LOC_BUS;
                o_mem_req <= loc_r == scm_pkg::SCM_LOC_BUS;
                o_mem_addr <= addr_r;
                o_mem_wdata <= dep_word;
                o_reg_we <= loc_r == scm_pkg::SCM_LOC_REG;
                o_reg_wdata <= dep_word;
                o_psw_we <= loc_r == scm_pkg::SCM_LOC_PSW;
                o_psw_wdata <= dep_word;
              end else begin
                st_r <= SCM_ST_MSG;
              end
              closed_r <= 1'b1;
              msg_idx_r <= 3'h0;
              if (i_rx_data == `SCM_CH_CR) begin
                // (RULE6) Echo then CR LF prompt
                msg_r[0] <= `SCM_CH_CR;
                msg_r[1] <= `SCM_CH_CR;
                msg_r[2] <= `SCM_CH_LF;
                msg_len_r <= 3'h2;
                after_r <= 2'h1;
              end else begin
                // (RULE11) No echo of LF
                msg_r[0] <= `SCM_CH_CR;
                msg_r[1] <= `SCM_CH_LF;
                msg_len_r <= 3'h1;
                if (closed_r || loc_r == scm_pkg::SCM_LOC_PSW) begin
                  // (RULE8) Status word or nothing open: close only
                  after_r <= 2'h1;
                end else begin
                  after_r <= 2'h3;
                  if (loc_r == scm_pkg::SCM_LOC_REG) begin
                    // (RULE9) Register wrap
                    reg_r <= reg_r + 3'h1;
                  end else begin
                    // (RULE7) (RULE10) Step within segment
                    addr_r <= {addr_r[ADDR_W-1:`SCM_SEG_BITS],
                               addr_r[`SCM_SEG_BITS-1:0] + `SCM_SEG_BITS'(2)};
                  end
                  msg_r[2] <= (loc_r == scm_pkg::SCM_LOC_REG) ? `SCM_CH_R : 8'h00;
                  msg_len_r <= (loc_r == scm_pkg::SCM_LOC_REG) ? 3'h4 : 3'h1;
                  msg_r[3] <= scm_oct_char(reg_r + 3'h1);
                  msg_r[4] <= `SCM_CH_SLASH;
                end
              end
              acc_r <= '0;
              have_r <= 1'b0;
            end else if (i_rx_data == `SCM_CH_G) begin
              // (RULE17) Echo and two nulls
              msg_r[0] <= `SCM_CH_G;
              msg_r[1] <= `SCM_CH_NUL;
              msg_r[2] <= `SCM_CH_NUL;
              msg_len_r <= 3'h2;
              msg_idx_r <= 3'h0;
              after_r <= 2'h0;
              go_step_r <= 2'h1;
              st_r <= SCM_ST_MSG;
            end else if (i_rx_data == `SCM_CH_P) begin
              // (RULE19) Start as echo begins
              msg_r[0] <= `SCM_CH_P;
              msg_len_r <= 3'h0;
              msg_idx_r <= 3'h0;
              after_r <= 2'h0;
              go_step_r <= 2'h0;
              o_run <= 1'b1;
              st_r <= SCM_ST_MSG;
            end else if (i_rx_data == `SCM_CH_H && HALT_TOGGLE_EN) begin
              // (RULE22) Toggle halt flip-flop
              o_halt_ff <= !o_halt_ff;
              msg_r[0] <= `SCM_CH_H;
              msg_r[1] <= `SCM_CH_CR;
              msg_r[2] <= `SCM_CH_LF;
              msg_len_r <= 3'h2;
              msg_idx_r <= 3'h0;
              after_r <= 2'h1;
              st_r <= SCM_ST_MSG;
            end else begin
              msg_r[0] <= `SCM_CH_QM;
              msg_r[1] <= `SCM_CH_CR;
              msg_r[2] <= `SCM_CH_LF;
              msg_len_r <= 3'h2;
              msg_idx_r <= 3'h0;
              after_r <= 2'h1;
              st_r <= SCM_ST_MSG;
            end
          end
        end
        SCM_ST_STORE: begin
          if (!o_mem_req || i_mem_done) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            st_r <= SCM_ST_MSG;
          end
        end
        SCM_ST_MSG: begin
          if (txc.ready) begin
            msg_idx_r <= msg_idx_r + 3'h1;
            if (msg_idx_r == msg_len_r) begin
              msg_idx_r <= 3'h0;
              if (go_step_r != 2'h0) begin
                st_r <= SCM_ST_START;
              end else if (o_run) begin
                st_r <= SCM_ST_RUN;
              end else begin
                unique case (after_r)
                  2'h0: st_r <= SCM_ST_PRINT;
                  2'h1: st_r <= SCM_ST_PROMPT;
                  2'h2: st_r <= SCM_ST_IDLE;
                  2'h3: st_r <= SCM_ST_FETCH;
                endcase
              end
            end
          end
        end
        SCM_ST_FETCH: begin
          opened_r <= 1'b1;
          closed_r <= 1'b0;
          if (loc_r == scm_pkg::SCM_LOC_BUS) begin
            o_mem_req <= 1'b1;
            o_mem_addr <= addr_r;
            if (o_mem_req && i_mem_done) begin
              o_mem_req <= 1'b0;
              word_r <= i_mem_rdata;
              st_r <= SCM_ST_PRINT;
            end
          end else begin
            o_reg_sel <= reg_r;
            word_r <= (loc_r == scm_pkg::SCM_LOC_PSW) ? i_psw_rdata : i_reg_rdata;
            st_r <= (o_reg_sel == reg_r) ? SCM_ST_PRINT : SCM_ST_FETCH;
          end
        end
        SCM_ST_PRINT: begin
          // (RULE1) Six digits then space
          msg_r[0] <= {7'b0011000, word_r[15]};
          for (int i = 1; i < `SCM_PRINT_DIGITS; i++) begin
            msg_r[i] <= scm_oct_char(word_r[17-3*i -: 3]);
          end
          msg_r[`SCM_PRINT_DIGITS] <= `SCM_CH_SP;
          msg_len_r <= 3'(`SCM_PRINT_DIGITS);
          msg_idx_r <= 3'h0;
          after_r <= (loc_r == scm_pkg::SCM_LOC_NONE) ? 2'h1 : 2'h2;
          st_r <= SCM_ST_MSG;
        end
        SCM_ST_START: begin
          go_step_r <= go_step_r + 2'h1;
          if (go_step_r == 2'h1) begin
            // (RULE17) Load counter, clear status
            o_reg_sel <= `SCM_PC_REG;
            o_reg_wdata <= have_r ? acc_r[15:0] : 16'h0000;
            o_reg_we <= 1'b1;
            o_psw_wdata <= 16'h0000;
            o_psw_we <= 1'b1;
            o_fps_clear <= 1'b1;
          end else if (go_step_r == 2'h2) begin
            o_bus_init <= 1'b1;
          end else begin
            // (RULE18) Halt skips the program
            go_step_r <= 2'h0;
            if (halt_req) begin
              st_r <= SCM_ST_PROMPT;
            end else begin
              o_run <= 1'b1;
              st_r <= SCM_ST_RUN;
            end
          end
        end
        SCM_ST_RUN: begin
          if (o_run && i_core_halted) begin
            // (RULE20) Re-entry prints counter
            o_run <= 1'b0;
            pc_show_r <= i_pc;
            st_r <= SCM_ST_REENTRY;
          end
        end
        SCM_ST_REENTRY: begin
          word_r <= pc_show_r;
          loc_r <= scm_pkg::SCM_LOC_NONE;
          msg_r[0] <= `SCM_CH_CR;
          msg_r[1] <= `SCM_CH_LF;
          msg_len_r <= 3'h1;
          msg_idx_r <= 3'h0;
          after_r <= 2'h0;
          st_r <= SCM_ST_MSG;
          go_step_r <= 2'h0;
          closed_r <= 1'b1;
          have_r <= 1'b0;
        end
      endcase
    end
  end
endmodule : scm_monitor
`default_nettype wire

// ---- scm_monitor_properties.sv ----
/*
  Port checker for the console monitor, bound into every scm_monitor.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module scm_monitor_chk #(
  parameter int ADDR_W = 22,
  parameter bit HALT_TOGGLE_EN = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic o_mem_req,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic i_mem_done,
  input wire logic o_reg_we,
  input wire logic o_psw_we,
  input wire logic [15:0] o_psw_wdata,
  input wire logic [15:0] i_psw_rdata,
  input wire logic o_run,
  input wire logic o_halt_ff
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_tx_held:
    assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("tx character changed before ready");
  chk_mem_held:
    assert property (o_mem_req && !i_mem_done |=> o_mem_req && $stable(o_mem_addr))
    else $error("bus request dropped or moved before done");
  chk_trace_kept:
    assert property (o_psw_we && o_psw_wdata != 16'h0000 |-> o_psw_wdata[4] == i_psw_rdata[4])
    else $error("status deposit altered trace bit");
  chk_codes_silent:
    assert property (o_tx_valid |-> !(o_tx_data inside {8'h02, 8'h08}))
    else $error("refused control code echoed");
  chk_reg_pulse:
    assert property (o_reg_we |=> !o_reg_we)
    else $error("register write longer than one cycle");
  chk_psw_pulse:
    assert property (o_psw_we |=> !o_psw_we)
    else $error("status write longer than one cycle");
  chk_reset_quiet:
    assert property ($fell(i_rst) |-> !o_run && !o_mem_req && !o_tx_valid)
    else $error("outputs active right after reset");
  chk_bus_when_run:
    assert property (o_run |-> !o_mem_req ##1 !o_mem_req)
    else $error("monitor bus access while running");
  chk_halt_ff_off:
    assert property (!HALT_TOGGLE_EN |-> !o_halt_ff)
    else $error("halt toggle set in variant without it");
endmodule : scm_monitor_chk
bind scm_monitor scm_monitor_chk #(.ADDR_W(ADDR_W), .HALT_TOGGLE_EN(HALT_TOGGLE_EN)) u_chk (.*);
`default_nettype wire

// ---- scm_pkg.sv ----
/*
  Types shared by the console monitor modules.
  Assumes nothing beyond the constants header.
*/
package scm_pkg;
  typedef enum logic [1:0] {
    SCM_LOC_NONE,
    SCM_LOC_BUS,
    SCM_LOC_REG,
    SCM_LOC_PSW
  } scm_loc_t;
endpackage : scm_pkg

// ---- scm_term_model.sv ----
/*
  Operator terminal on the console line: strobes typed characters in and
  collects printed ones. Assumes the bench waits for each reply to finish.
*/
`timescale 1ns/1ps
`default_nettype none
module scm_term_model (
  input wire logic i_ref_clk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_tx_ready
);
  logic [31:0] lf_r;
  logic [7:0] got [$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_tx_ready = 1'b0;
    lf_r = 32'h0000C417;
  end
  // Idle data line is inverted so a stale character is never read as fresh
  task automatic send_char(input logic [7:0] c);
    @(negedge i_ref_clk);
    o_rx_valid = 1'b1;
    o_rx_data = c;
    @(negedge i_ref_clk);
    o_rx_valid = 1'b0;
    o_rx_data = ~c;
  endtask : send_char
  // Printer stalls at random, so both prompt and slow replies occur
  always @(negedge i_ref_clk) begin
    lf_r <= {lf_r[30:0], lf_r[31] ^ lf_r[21] ^ lf_r[1] ^ lf_r[0]};
    o_tx_ready <= lf_r[0] | lf_r[3];
  end
  always @(posedge i_ref_clk) begin
    if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
  end
endmodule : scm_term_model
`default_nettype wire

// ---- scm_tx_if.sv ----
/*
  Character hand-off from the command interpreter to the output sequencer.
  Assumes one clock; valid held until ready.
*/
`timescale 1ns/1ps
`default_nettype none
interface scm_tx_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : scm_tx_if
`default_nettype wire

// ---- scm_tx_stage.sv ----
/*
  One-character output stage towards the serial transmitter.
  Assumes the transmitter raises i_tx_ready when it can take a character.
*/
`timescale 1ns/1ps
`default_nettype none
module scm_tx_stage (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  scm_tx_if.snk tx,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data
);
  assign tx.ready = !o_tx_valid;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
    end else if (tx.valid && !o_tx_valid) begin
      o_tx_valid <= 1'b1;
      o_tx_data <= tx.data;
    end else if (o_tx_valid && i_tx_ready) begin
      o_tx_valid <= 1'b0;
    end
  end
endmodule : scm_tx_stage
`default_nettype wire

// ---- testbench.sv ----
/*
  Self-checking bench for the console monitor with bus and core models.
  Assumes the terminal model drives the console line and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int AW = 22;
  logic i_ref_clk, i_rst, i_rx_valid, i_tx_ready, o_tx_valid, o_mem_req, o_mem_we, i_mem_done;
  logic o_reg_we, o_psw_we, o_fps_clear, o_bus_init, o_run, o_halt_ff, i_halt_sw, i_core_halted;
  logic [7:0] i_rx_data, o_tx_data;
  logic [AW-1:0] o_mem_addr, last_addr, a;
  logic [15:0] o_mem_wdata, i_mem_rdata, o_reg_wdata, i_reg_rdata, o_psw_wdata, i_psw_rdata;
  logic [15:0] i_pc, d;
  logic [2:0] o_reg_sel;
  logic [15:0] regs [8];
  logic [15:0] mem [int];
  logic [7:0] ex [$];
  logic [7:0] bad_c [3] = '{8'h00, 8'h02, 8'h08};
  logic [31:0] lf, rs;
  logic [1:0] seen;
  int err_total, n_tests;
  assign i_reg_rdata = regs[o_reg_sel];
  assign i_pc = regs[7];
  assign i_core_halted = !o_run || i_halt_sw;
  scm_monitor #(.ADDR_W(AW)) u_scm_monitor (.*);
  scm_term_model u_term (.i_ref_clk(i_ref_clk), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
    .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_tx_ready(i_tx_ready));
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic string oct6(input logic [15:0] v);
    return $sformatf("%06o", v);
  endfunction : oct6
  // Line feed stays inside the 32-Kword segment
  function automatic logic [AW-1:0] step(input logic [AW-1:0] x);
    return {x[AW-1:16], x[15:0] + 16'h0002};
  endfunction : step
  // Bus with random latency, released data inverted; register and status models
  always @(negedge i_ref_clk) begin
    i_mem_done <= 1'b0;
    i_mem_rdata <= ~i_mem_rdata;
    lf = nxt(lf);
    if (o_mem_req && !i_mem_done && lf[1:0] == 2'h0) begin
      if (!mem.exists(o_mem_addr)) mem[o_mem_addr] = lf[31:16];
      if (o_mem_we) mem[o_mem_addr] = o_mem_wdata;
      i_mem_rdata <= mem[o_mem_addr];
      last_addr <= o_mem_addr;
      i_mem_done <= 1'b1;
    end
    if (o_reg_we) regs[o_reg_sel] <= o_reg_wdata;
    if (o_psw_we) i_psw_rdata <= o_psw_wdata;
    seen <= seen | {o_bus_init, o_fps_clear};
  end
  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Next character only once the reply and any bus cycle are over
  task automatic key(input logic [7:0] c);
    int q;
    u_term.send_char(c);
    q = 0;
    for (int t = 0; t < 5000 && q < 40; t++) begin
      @(negedge i_ref_clk);
      q = (o_tx_valid || o_mem_req) ? 0 : q + 1;
    end
    if (q < 40) begin
      err_total++;
      wrap_up();
    end
  endtask : key
  task automatic typ(input string s);
    foreach (s[i]) key(s[i]);
  endtask : typ
  task automatic put(input string s);
    foreach (s[i]) ex.push_back(s[i]);
  endtask : put
  task automatic chk_out(input string nm);
    logic bad;
    n_tests++;
    bad = (ex.size() != u_term.got.size());
    foreach (ex[i]) if (!bad && ex[i] !== u_term.got[i]) bad = 1'b1;
    if (bad) begin
      err_total++;
      $display("Error %s expected %p seen %p", nm, ex, u_term.got);
    end
    ex.delete();
    u_term.got.delete();
  endtask : chk_out
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk_val
  initial begin
    i_rst = 1'b1;
    i_mem_done = 1'b0;
    i_halt_sw = 1'b0;
    i_mem_rdata = 16'h0000;
    i_psw_rdata = 16'h80FF;
    seen = 2'h0;
    lf = 32'h0000C417;
    rs = 32'h0000C417;
    err_total = 0;
    n_tests = 0;
    foreach (regs[i]) regs[i] = 16'(i * 3 + 5);
    repeat (16) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (300) @(negedge i_ref_clk);
    put("@");
    chk_out("prompt");
    typ("/");
    put("/?\015\n@");
    chk_out("bare slash first");
    typ("1000/");
    put({"1000/", oct6(mem[32'h200]), " "});
    chk_out("open 1000");
    chk_val("read address", 32'h200, last_addr);
    typ("1234\015");
    put("1234\015\015\n@");
    chk_out("close echo");
    chk_val("deposit 1000", 32'h29C, mem[32'h200]);
    typ("/");
    put({"/", oct6(16'h029C), " "});
    chk_out("reopen");
    typ("\015");
    put("\015\015\n@");
    chk_out("plain close");
    chk_val("unchanged", 32'h29C, mem[32'h200]);
    foreach (bad_c[i]) begin
      key(bad_c[i]);
      put("?\015\n@");
      chk_out("refused code");
    end
    for (int k = 0; k < 4; k++) begin
      rs = nxt(rs);
      a = {4'h0, rs[17:1], 1'b0};
      d = rs[31:16];
      typ($sformatf("%0o/", a));
      put({$sformatf("%0o/", a), oct6(mem[a]), " "});
      chk_out("open random");
      typ($sformatf("%0o\n", d));
      chk_val("lf deposit", d, mem[a]);
      chk_val("lf next", step(a), last_addr);
      chk_val("lf not echoed", {8'h0D, 8'h0A}, {u_term.got[$ - 8], u_term.got[$ - 7]});
      typ("\015");
      u_term.got.delete();
    end
    typ("577776/\n\015");
    chk_val("segment wrap", 32'h20000, last_addr);
    u_term.got.delete();
    typ("RS/");
    put({"RS/", oct6(16'h80FF), " "});
    chk_out("open status");
    typ("0\015");
    chk_val("trace kept", 32'h10, i_psw_rdata);
    typ("$S/");
    u_term.got.delete();
    key(8'h0A);
    put("\015\n@");
    chk_out("lf on status");
    typ("R7/");
    u_term.got.delete();
    key(8'h0A);
    put({"\015\nR0/", oct6(regs[0]), " "});
    chk_out("register wrap");
    chk_val("register zero", 32'h0, o_reg_sel);
    typ("\015R477/");
    u_term.got.delete();
    typ("5\015");
    chk_val("477 is status", 32'h15, i_psw_rdata);
    u_term.got.delete();
    typ("200G");
    put("200G");
    ex = {ex, 8'h00, 8'h00};
    chk_out("go nulls");
    chk_val("pc loaded", 32'h80, regs[7]);
    chk_val("status cleared", 32'h0, i_psw_rdata);
    chk_val("init and fps", 32'h3, seen);
    chk_val("running", 32'h1, o_run);
    i_halt_sw = 1'b1;
    repeat (300) @(negedge i_ref_clk);
    put({"\015\n", oct6(16'h0080), " @"});
    chk_out("halt reentry");
    typ("P");
    put({"P\015\n", oct6(16'h0080), " @"});
    chk_out("proceed step");
    typ("G");
    ex = {8'h47, 8'h00, 8'h00, 8'h40};
    chk_out("go halted");
    chk_val("pc zero", 32'h0, regs[7]);
    chk_val("not running", 32'h0, o_run);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
